// ---- design/scl_pkg.sv ----
// How it works
// R1 - Every accepted configuration bit is stored in the internal configuration memory; the code stores only the first 64 words, later words are dropped.
// R2 - Mode pins reading 111 (high, mid, low) select slave serial loading.
// R3 - Weak pull-ups on the mode pins make slave serial the mode when they float.
// R4 - In slave serial the config clock pin is an input and is never driven.
// R5 - In slave serial the source sets up each bit before a rising config clock edge, where it is captured.
// R6 - After the own configuration is complete, further incoming bits are forwarded to the serial data output.
// R7 - The serial data output changes only on falling config clock edges.
// R8 - In master serial the config clock pin is driven as an output to the serial PROM.
// R9 - In master serial the PROM gives one bit per generated clock, captured on its rising edge.
// R10 - The master config clock comes from an internal divider, slow by default, faster once the bitstream says so.
// R11 - User I/O pull-ups are off during configuration while the pull-up select input is high, on while it is low.
// R12 - With persist set the config pins keep their role after loading, otherwise all but clock, program and done go to user I/O.
// R13 - Persist has no effect on the boundary-scan pins.
// R14 - Mode codes other than the two serial ones leave the serial loader idle.
`default_nettype none
package scl_pkg;
    // ==========================================
    // Register map (byte addresses)
    localparam logic [11:0] REG_CTRL    = 12'h000;
    localparam logic [11:0] REG_STATUS  = 12'h004;
    localparam logic [11:0] REG_LEN     = 12'h008;
    localparam logic [11:0] REG_WCOUNT  = 12'h00c;
    localparam logic [11:0] MEM_BASE    = 12'h100;
    localparam logic [11:0] MEM_LIMIT   = 12'h200;
    localparam int          CTRL_EN     = 0;
    localparam int          CTRL_PERSIST = 1;
    localparam logic [1:0]  CTRL_RST    = 2'h0;
    localparam logic [6:0]  LEN_RST     = 7'h40;
    // ==========================================
    // Configuration memory and word stream
    localparam int          MEM_DEPTH   = 64;
    localparam int          MEM_AW      = 6;
    localparam logic [6:0]  WIDX_FULL   = 7'h40;
    localparam logic [4:0]  LAST_BIT    = 5'h1f;
    localparam int          SPEED_LSB   = 0;
    localparam logic [1:0]  SPEED_RST   = 2'h0;
    // ==========================================
    // Mode codes and master clock half periods in core cycles
    localparam logic [2:0]  MODE_SLAVE_SERIAL  = 3'h7;
    localparam logic [2:0]  MODE_MASTER_SERIAL = 3'h0;
    localparam logic [3:0]  HALF_SLOW   = 4'h8;
    localparam logic [3:0]  HALF_MED    = 4'h4;
    localparam logic [3:0]  HALF_FAST   = 4'h2;
    localparam logic [3:0]  HALF_MAX    = 4'h1;
    // ==========================================
    // Bus
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic        HRESP_OKAY    = 1'b0;

    typedef struct packed {
        logic mode_select_hi;
        logic mode_select_mid;
        logic mode_select_lo;
        logic pullup_disable_select;
        logic program_request_n;
    } scl_pins_t;

    // Floating pins read high, so the synchronisers start in slave serial with pull-ups off
    localparam scl_pins_t PINS_RST = 5'h1f;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOAD = 3'b010,
        ST_DONE = 3'b100
    } scl_state_t;

    typedef struct packed {
        logic        wr;
        logic [11:0] addr;
    } scl_aphase_t;
endpackage
`default_nettype wire

// ---- design/scl_loader.sv ----
`default_nettype none
module scl_loader (
    input  wire logic              core_clk_in,
    input  wire logic              resetn_in,
    input  wire logic              ce_in,
    // AHB-Lite slave
    input  wire logic              hsel_in,
    input  wire logic [31:0]       haddr_in,
    input  wire logic [1:0]        htrans_in,
    input  wire logic              hwrite_in,
    input  wire logic [2:0]        hsize_in,
    input  wire logic [31:0]       hwdata_in,
    input  wire logic              hready_in,
    output logic      [31:0]       hrdata_out,
    output logic                   hreadyout_out,
    output logic                   hresp_out,
    // Configuration pins
    input  wire scl_pkg::scl_pins_t pins_in,
    input  wire logic              config_clock_in,
    output logic                   config_clock_out,
    output logic                   config_clock_oe_out,
    input  wire logic              din_in,
    output logic                   dout_out,
    output logic                   mode_pullup_en_out,
    output logic                   user_pullup_en_out,
    output logic                   user_io_release_out,
    output logic                   config_done_out
);
    // ==========================================
    // Pin synchronisers
    scl_pkg::scl_pins_t pins_m;
    scl_pkg::scl_pins_t pins_s;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pins_m <= scl_pkg::PINS_RST;
            pins_s <= scl_pkg::PINS_RST;
        end else if (ce_in) begin
            pins_m <= pins_in;
            pins_s <= pins_m;
        end
    end

    wire logic [2:0] mode_s     = {pins_s.mode_select_hi, pins_s.mode_select_mid, pins_s.mode_select_lo};
    wire logic       is_slave   = (mode_s == scl_pkg::MODE_SLAVE_SERIAL);   // R2
    wire logic       is_master  = (mode_s == scl_pkg::MODE_MASTER_SERIAL);
    wire logic       serial_ok  = is_slave | is_master;                     // R14

    // ==========================================
    // Control registers and state
    logic [1:0]             ctrl;
    logic [6:0]             len;
    logic [6:0]             widx;
    logic [1:0]             speed;
    logic                   arm;
    scl_pkg::scl_state_t    state;
    scl_pkg::scl_state_t    next_state;
    logic [31:0]            mem [scl_pkg::MEM_DEPTH];

    wire logic ctrl_en  = ctrl[scl_pkg::CTRL_EN];
    wire logic persist  = ctrl[scl_pkg::CTRL_PERSIST];
    wire logic go       = ctrl_en & pins_s.program_request_n & serial_ok;

    // ==========================================
    // Word crossing from the link domain
    logic [31:0] word_l;
    logic        tgl_l;
    logic        done_l;
    logic        tgl_m;
    logic        tgl_s;
    logic        tgl_d;
    logic        ldone_m;
    logic        ldone_s;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tgl_m   <= 1'b0;
            tgl_s   <= 1'b0;
            tgl_d   <= 1'b0;
            ldone_m <= 1'b0;
            ldone_s <= 1'b0;
        end else if (ce_in) begin
            tgl_m   <= tgl_l;
            tgl_s   <= tgl_m;
            tgl_d   <= tgl_s;
            ldone_m <= done_l;
            ldone_s <= ldone_m;
        end
    end

    // word_l is held for a whole word of link clocks after its toggle, so it is settled when read here
    wire logic                     wevt     = tgl_s ^ tgl_d;
    wire logic                     wstore   = wevt & (widx < scl_pkg::WIDX_FULL);
    wire logic [scl_pkg::MEM_AW-1:0] widx_lo = widx[scl_pkg::MEM_AW-1:0];

    // ==========================================
    // Load sequencer
    always_comb begin
        next_state = state;
        case (state)
            scl_pkg::ST_IDLE: begin
                if (go && !ldone_s) begin
                    next_state = scl_pkg::ST_LOAD;
                end
            end
            scl_pkg::ST_LOAD: begin
                if (!go) begin
                    next_state = scl_pkg::ST_IDLE;              // R14
                end else if (ldone_s) begin
                    next_state = scl_pkg::ST_DONE;
                end
            end
            scl_pkg::ST_DONE: begin
                if (!ctrl_en || !pins_s.program_request_n) begin
                    next_state = scl_pkg::ST_IDLE;
                end
            end
            default: next_state = scl_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= scl_pkg::ST_IDLE;
            arm   <= 1'b0;
        end else if (ce_in) begin
            state <= next_state;
            arm   <= (next_state != scl_pkg::ST_IDLE);
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            widx  <= 7'h00;
            speed <= scl_pkg::SPEED_RST;
        end else if (ce_in) begin
            if (state == scl_pkg::ST_IDLE) begin
                widx  <= 7'h00;
                speed <= scl_pkg::SPEED_RST;
            end else if (wstore) begin
                widx <= widx + 7'h01;
                if (widx == 7'h00) begin
                    speed <= word_l[scl_pkg::SPEED_LSB +: 2];   // R10
                end
            end
        end
    end

    // Memory has no reset; its content is only meaningful below the word count
    always_ff @(posedge core_clk_in) begin
        if (ce_in && wstore && state != scl_pkg::ST_IDLE) begin
            mem[widx_lo] <= word_l;                             // R1
        end
    end

    // ==========================================
    // Master clock divider
    function automatic logic [3:0] half_of(input logic [1:0] sel);
        case (sel)
            2'h0:    half_of = scl_pkg::HALF_SLOW;
            2'h1:    half_of = scl_pkg::HALF_MED;
            2'h2:    half_of = scl_pkg::HALF_FAST;
            default: half_of = scl_pkg::HALF_MAX;
        endcase
    endfunction

    logic [3:0] div_cnt;
    logic       config_clock;
    logic       config_clock_oe;
    wire logic  master_run = arm & is_master;
    wire logic  div_wrap   = (div_cnt >= half_of(speed) - 4'h1);

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_cnt <= 4'h0;
            config_clock    <= 1'b0;
            config_clock_oe <= 1'b0;
        end else if (ce_in) begin
            config_clock_oe <= master_run;                              // R4 R8
            if (!master_run) begin
                div_cnt <= 4'h0;
                config_clock    <= 1'b0;
            end else if (div_wrap) begin
                div_cnt <= 4'h0;
                config_clock    <= ~config_clock;                               // R10
            end else begin
                div_cnt <= div_cnt + 4'h1;
            end
        end
    end

    assign config_clock_out    = config_clock;
    assign config_clock_oe_out = config_clock_oe;

    // ==========================================
    // Pin role outputs
    logic pull_en;
    logic release_q;
    logic done_q;
    logic mode_pu;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pull_en   <= 1'b0;
            release_q <= 1'b0;
            done_q    <= 1'b0;
            mode_pu   <= 1'b1;
        end else if (ce_in) begin
            mode_pu   <= 1'b1;                                  // R3
            pull_en   <= (state != scl_pkg::ST_DONE) & ~pins_s.pullup_disable_select;  // R11
            // Covers only the configuration pins; the scan pins are outside this block R13
            release_q <= (state == scl_pkg::ST_DONE) & ~persist;                       // R12
            done_q    <= (state == scl_pkg::ST_DONE);
        end
    end

    assign mode_pullup_en_out  = mode_pu;
    assign user_pullup_en_out  = pull_en;
    assign user_io_release_out = release_q;
    assign config_done_out     = done_q;

    // ==========================================
    // AHB-Lite slave, zero wait states
    scl_pkg::scl_aphase_t aph;
    logic [31:0]          rdata;
    logic [31:0]          next_rdata;
    logic                 hready_q;

    wire logic        take   = hsel_in & hready_in & (htrans_in == scl_pkg::HTRANS_NONSEQ);
    wire logic [11:0] raddr  = haddr_in[11:0];
    wire logic        in_mem = (raddr >= scl_pkg::MEM_BASE) && (raddr < scl_pkg::MEM_LIMIT);

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (raddr == scl_pkg::REG_CTRL) begin
            next_rdata = {30'h0, ctrl};
        end else if (raddr == scl_pkg::REG_STATUS) begin
            next_rdata = {23'h0, speed, mode_s, ldone_s, state};
        end else if (raddr == scl_pkg::REG_LEN) begin
            next_rdata = {25'h0, len};
        end else if (raddr == scl_pkg::REG_WCOUNT) begin
            next_rdata = {25'h0, widx};
        end else if (in_mem) begin
            next_rdata = mem[raddr[scl_pkg::MEM_AW+1:2]];
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            aph      <= '0;
            rdata    <= 32'h0000_0000;
            hready_q <= 1'b1;
            ctrl     <= scl_pkg::CTRL_RST;
            len      <= scl_pkg::LEN_RST;
        end else if (ce_in) begin
            hready_q <= 1'b1;
            aph.wr   <= take & hwrite_in;
            aph.addr <= raddr;
            if (take && !hwrite_in) begin
                rdata <= next_rdata;
            end
            if (aph.wr && aph.addr == scl_pkg::REG_CTRL) begin
                ctrl <= hwdata_in[1:0];
            end else if (aph.wr && aph.addr == scl_pkg::REG_LEN) begin
                len <= hwdata_in[6:0];
            end
        end
    end

    assign hrdata_out    = rdata;
    assign hreadyout_out = hready_q;
    assign hresp_out     = scl_pkg::HRESP_OKAY;

    // ==========================================
    // Link domain: capture on rising, forward on falling config clock
    logic        arm_m;
    logic        arm_l;
    logic [4:0]  bitpos;
    logic [6:0]  wcnt;
    logic [31:0] shreg;
    logic        fwd_bit;
    logic        dout_q;
    wire logic [31:0] next_shreg = {shreg[30:0], din_in};

    always_ff @(posedge config_clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            arm_m   <= 1'b0;
            arm_l   <= 1'b0;
            bitpos  <= 5'h00;
            wcnt    <= 7'h00;
            shreg   <= 32'h0000_0000;
            word_l  <= 32'h0000_0000;
            tgl_l   <= 1'b0;
            done_l  <= 1'b0;
            fwd_bit <= 1'b1;
        end else begin
            arm_m <= arm;
            arm_l <= arm_m;
            if (!arm_l) begin
                bitpos <= 5'h00;
                wcnt   <= 7'h00;
                done_l <= 1'b0;
            end else if (!done_l) begin
                shreg  <= next_shreg;                           // R5 R9
                bitpos <= bitpos + 5'h01;
                if (bitpos == scl_pkg::LAST_BIT) begin
                    word_l <= next_shreg;                       // R1
                    tgl_l  <= ~tgl_l;
                    wcnt   <= wcnt + 7'h01;
                    done_l <= (wcnt + 7'h01 == len);
                end
            end else begin
                fwd_bit <= din_in;                              // R6
            end
        end
    end

    always_ff @(negedge config_clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dout_q <= 1'b1;
        end else if (done_l) begin
            dout_q <= fwd_bit;                                  // R7
        end
    end

    assign dout_out = dout_q;

    // ==========================================
    // Checks
    sequence s_slow_high;
        (config_clock_out || !master_run || speed != scl_pkg::SPEED_RST) [*8];
    endsequence

    slave_clk_in_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R4
        ce_in && is_slave |=> !config_clock_oe_out)
        else $error("config clock driven in slave serial mode");
    master_clk_out_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R8
        ce_in && master_run |=> config_clock_oe_out)
        else $error("config clock not driven in master serial mode");
    slow_half_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R10
        $rose(config_clock_out) && speed == scl_pkg::SPEED_RST |-> s_slow_high)
        else $error("slow config clock high phase too short");
    slave_start_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R2
        ce_in && state == scl_pkg::ST_IDLE && is_slave && ctrl_en && pins_s.program_request_n && !ldone_s
        |=> state == scl_pkg::ST_LOAD)
        else $error("slave serial load did not start");
    idle_other_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R14
        ce_in && state == scl_pkg::ST_IDLE && !serial_ok |=> state == scl_pkg::ST_IDLE)
        else $error("loader left idle in a non-serial mode");
    word_store_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R1
        ce_in && wstore && state != scl_pkg::ST_IDLE
        |=> widx == $past(widx) + 7'h01 && mem[$past(widx_lo)] == $past(word_l))
        else $error("configuration word not stored");
    pullup_sel_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R11
        ce_in && state != scl_pkg::ST_DONE |=> user_pullup_en_out == !$past(pins_s.pullup_disable_select))
        else $error("user pull-up enable wrong during configuration");
    io_release_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R12
        ce_in && state == scl_pkg::ST_DONE |=> user_io_release_out == !$past(persist))
        else $error("pin release disagrees with persist");
    link_capture_a: assert property (@(posedge config_clock_in) disable iff (!resetn_in) // R5
        arm_l && !done_l |=> shreg[0] == $past(din_in))
        else $error("serial bit not captured on rising edge");
endmodule
`default_nettype wire

// ---- verif/scl_source_model.sv ----
`default_nettype none
module scl_source_model (
    input  wire logic pad_clk_in,
    output logic      clk_drive_out,
    output logic      din_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] words [0:3];
    int          ptr;
    // ==========================================
    // Serial source, first bit of a word is its msb
    task automatic present();
        if (ptr < 128)
            din_out = words[ptr / 32][31 - ptr % 32];
        else
            din_out = ~din_out; // Past the stream the line holds no stable value
    endtask
    task automatic restart();
        ptr = 0;
        present();
    endtask
    // Slave clock runs only inside a frame, 6 ns period
    task automatic run_clocks(input int n);
        repeat (n) begin
            #3 clk_drive_out = 1'b1;
            #3 clk_drive_out = 1'b0;
        end
    endtask
    initial begin
        clk_drive_out = 1'b0;
        din_out = 1'b0;
        ptr = 0;
    end
    always @(posedge pad_clk_in) ptr <= ptr + 1;
    // New bit set up at the falling edge, well before the next rise
    always @(negedge pad_clk_in) present();
endmodule
`default_nettype wire

// ---- verif/scl_loader_bench.sv ----
`default_nettype none
module scl_loader_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic               core_clk_in, resetn_in, hsel, hwrite, hready, hresp;
    logic [31:0]        haddr, hwdata, hrdata, rd;
    logic [1:0]         htrans;
    logic [2:0]         hsize;
    scl_pkg::scl_pins_t pins;
    logic               clk_out, clk_oe, clk_drive, din, dout, mpu, upu, rel, done, ce;
    wire logic          pad_clk;
    int                 n_errors, check_count;
    // Pad wire: whoever has the enable owns the clock pin
    assign pad_clk = clk_oe ? clk_out : clk_drive;
    scl_loader scl_loader_inst (
        .core_clk_in(core_clk_in), .resetn_in(resetn_in), .ce_in(ce),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .pins_in(pins),
        .config_clock_in(pad_clk), .config_clock_out(clk_out), .config_clock_oe_out(clk_oe),
        .din_in(din), .dout_out(dout), .mode_pullup_en_out(mpu), .user_pullup_en_out(upu),
        .user_io_release_out(rel), .config_done_out(done));
    scl_source_model scl_source_model_inst (
        .pad_clk_in(pad_clk), .clk_drive_out(clk_drive), .din_out(din));
    // ==========================================
    // Common tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic timeout(input string what);
        n_errors++;
        $display("ERROR %s expected event seen timeout", what);
        end_sim();
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 20; i++) begin
            @(posedge core_clk_in);
            if (hready === 1'b1) return;
        end
        timeout("hready");
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge core_clk_in);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= scl_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic wait_done(input logic lvl);
        for (int i = 0; i < 2000; i++) begin
            @(posedge core_clk_in);
            if (done === lvl) return;
        end
        timeout("done");
    endtask
    task automatic set_pins(input logic [2:0] m, input logic pud, input logic prg);
        @(posedge core_clk_in);
        pins <= {m, pud, prg};
        repeat (4) @(posedge core_clk_in);
    endtask
    // Rises of the generated clock as seen at core edges
    task automatic wait_rises(input int n);
        logic prev;
        prev = clk_out;
        for (int i = 0; i < 4000 && n > 0; i++) begin
            @(posedge core_clk_in);
            if (clk_out === 1'b1 && prev === 1'b0) n--;
            prev = clk_out;
        end
        if (n > 0) timeout("clock");
    endtask
    task automatic measure(output int p);
        time t0;
        wait_rises(1);
        t0 = $time;
        wait_rises(1);
        p = int'(($time - t0) / 10);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        check("oe", clk_oe, 32'h0);
        check("dout", dout, 32'h1);
        check("mode_pu", mpu, 32'h1);
        bus(1'b0, scl_pkg::REG_CTRL, 32'h0);
        check("ctrl", rd, {30'h0, scl_pkg::CTRL_RST});
        bus(1'b0, scl_pkg::REG_LEN, 32'h0);
        check("len", rd, {25'h0, scl_pkg::LEN_RST});
        bus(1'b0, scl_pkg::REG_STATUS, 32'h0);
        check("mode", {29'h0, rd[6:4]}, 32'h7);
        bus(1'b1, 12'h080, 32'hffff_ffff);
        bus(1'b0, 12'h080, 32'h0);
        check("unmapped", rd, 32'h0);
        // A write made while the clock enable is low must be lost
        ce <= 1'b0;
        bus(1'b1, scl_pkg::REG_LEN, 32'h5);
        @(posedge core_clk_in);
        ce <= 1'b1;
        bus(1'b0, scl_pkg::REG_LEN, 32'h0);
        check("len_frozen", rd, {25'h0, scl_pkg::LEN_RST});
    endtask
    task automatic t_other_mode();
        set_pins(3'h3, 1'b1, 1'b1);
        bus(1'b1, scl_pkg::REG_CTRL, 32'h1);
        scl_source_model_inst.restart();
        scl_source_model_inst.run_clocks(32);
        repeat (8) @(posedge core_clk_in);
        check("oe", clk_oe, 32'h0);
        bus(1'b0, scl_pkg::REG_STATUS, 32'h0);
        check("state", {29'h0, rd[2:0]}, 32'h1);
        bus(1'b0, scl_pkg::REG_WCOUNT, 32'h0);
        check("wcount", rd, 32'h0);
        bus(1'b1, scl_pkg::REG_CTRL, 32'h0);
    endtask
    task automatic t_slave();
        logic [31:0] w2;
        logic        e;
        w2 = 32'ha5c3_0000;
        scl_source_model_inst.words[0] = 32'hdead_0001;
        scl_source_model_inst.words[1] = 32'h8001_7ffe;
        scl_source_model_inst.words[2] = w2;
        set_pins(3'h7, 1'b1, 1'b1);
        bus(1'b1, scl_pkg::REG_LEN, 32'h2);
        bus(1'b1, scl_pkg::REG_CTRL, 32'h1);
        repeat (6) @(posedge core_clk_in);
        bus(1'b0, scl_pkg::REG_STATUS, 32'h0);
        check("state", {29'h0, rd[2:0]}, 32'h2);
        check("user_pu", upu, 32'h0);
        // Two link edges carry the arm flag across before bits are taken
        scl_source_model_inst.run_clocks(2);
        scl_source_model_inst.restart();
        scl_source_model_inst.run_clocks(64);
        check("oe", clk_oe, 32'h0);
        wait_done(1'b1);
        check("dout", dout, 32'h1);
        bus(1'b0, scl_pkg::MEM_BASE, 32'h0);
        check("mem0", rd, 32'hdead_0001);
        bus(1'b0, scl_pkg::MEM_BASE + 12'h4, 32'h0);
        check("mem1", rd, 32'h8001_7ffe);
        bus(1'b0, scl_pkg::REG_WCOUNT, 32'h0);
        check("wcount", rd, 32'h2);
        check("release", rel, 32'h1);
        fork
            scl_source_model_inst.run_clocks(8);
            for (int k = 0; k < 8; k++) begin
                @(posedge pad_clk);
                #1;
                e = (k > 0) ? w2[32 - k] : 1'b1;
                check("dout_hold", dout, {31'h0, e});
                @(negedge pad_clk);
                #1;
                check("dout_fwd", dout, {31'h0, w2[31 - k]});
            end
        join
    endtask
    task automatic t_persist();
        set_pins(3'h7, 1'b0, 1'b0);
        wait_done(1'b0);
        set_pins(3'h7, 1'b0, 1'b1);
        bus(1'b1, scl_pkg::REG_CTRL, 32'h0);
        // The link done flag only clears on link edges seen while disarmed
        scl_source_model_inst.run_clocks(3);
        bus(1'b1, scl_pkg::REG_LEN, 32'h1);
        bus(1'b1, scl_pkg::REG_CTRL, 32'h3);
        repeat (6) @(posedge core_clk_in);
        check("user_pu", upu, 32'h1);
        scl_source_model_inst.run_clocks(2);
        scl_source_model_inst.restart();
        scl_source_model_inst.run_clocks(32);
        wait_done(1'b1);
        check("release", rel, 32'h0);
        bus(1'b1, scl_pkg::REG_CTRL, 32'h0);
        wait_done(1'b0);
        scl_source_model_inst.run_clocks(3);
    endtask
    task automatic t_master();
        int p;
        scl_source_model_inst.words[0] = 32'h1234_5672;
        scl_source_model_inst.words[1] = 32'h0f0f_c3c3;
        set_pins(3'h0, 1'b1, 1'b1);
        bus(1'b1, scl_pkg::REG_LEN, 32'h2);
        bus(1'b1, scl_pkg::REG_CTRL, 32'h1);
        // The first two generated edges arm the link side; the stream starts after them
        wait_rises(2);
        scl_source_model_inst.restart();
        measure(p);
        check("oe", clk_oe, 32'h1);
        check("slow", p, {27'h0, scl_pkg::HALF_SLOW, 1'b0});
        wait_rises(36);
        measure(p);
        check("fast", p, {27'h0, scl_pkg::HALF_FAST, 1'b0});
        wait_done(1'b1);
        bus(1'b0, scl_pkg::MEM_BASE, 32'h0);
        check("mem0", rd, 32'h1234_5672);
        bus(1'b0, scl_pkg::MEM_BASE + 12'h4, 32'h0);
        check("mem1", rd, 32'h0f0f_c3c3);
        bus(1'b1, scl_pkg::REG_CTRL, 32'h0);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    initial begin
        resetn_in = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        pins = {3'h7, 1'b1, 1'b1};
        n_errors = 0;
        check_count = 0;
        scl_source_model_inst.run_clocks(2);
        repeat (8) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        t_reset();
        t_other_mode();
        t_slave();
        t_persist();
        t_master();
        end_sim();
    end
endmodule
`default_nettype wire
